// >>> rtl/aist_defines.vh
`ifndef AIST_DEFINES_VH
`define AIST_DEFINES_VH
// Word indexes; byte address is four times the index
`define AIST_IDX_CTRL 4'h0
`define AIST_IDX_SCAN_DIV 4'h1
`define AIST_IDX_SCAN_DLY 4'h2
`define AIST_IDX_CONV_DIV 4'h3
`define AIST_IDX_CONV_DLY 4'h4
`define AIST_IDX_CHANS 4'h5
`define AIST_IDX_BUF 4'h6
`define AIST_IDX_PRE 4'h7
`define AIST_IDX_STATUS 4'h8
`define AIST_IDX_COUNT 4'h9
// Control fields
`define AIST_C_START 0
`define AIST_C_STOP 1
`define AIST_C_CONT 2
`define AIST_C_REF_EN 3
`define AIST_C_SCAN_EXT 4
`define AIST_C_CONV_EXT 5
`define AIST_C_SINGLE 6
`define AIST_C_TB_LO 7
`define AIST_C_TB_HI 8
`define AIST_C_TB_FALL 9
`define AIST_C_CTB_20M 10
`define AIST_C_SCAN_FALL 11
`define AIST_C_CONV_FALL 12
`define AIST_C_BEGIN_FALL 13
`define AIST_C_REF_FALL 14
`define AIST_C_GATE_HIGH 15
`define AIST_C_LEVEL_OUT 16
`define AIST_C_HOLD_LOW 17
`define AIST_C_HW_BEGIN 18
`define AIST_CTRL_W 19
`define AIST_CTRL_RST 19'h08000
`define AIST_CTRL_PULSE_MASK 19'h00003
// Scan timebase select codes
`define AIST_TB_20M 2'h0
`define AIST_TB_100K 2'h1
`define AIST_TB_EXT 2'h2
// Reset values
`define AIST_SCAN_DLY_RST 16'h0002
`define AIST_CONV_DLY_RST 16'h0003
`define AIST_DIV_RST 16'h0004
`define AIST_CHANS_RST 16'h0001
`define AIST_BUF_RST 16'h0010
// Timing
`define AIST_CLK_NS 5
`define AIST_TB20_NS 50
`define AIST_TB100K_NS 10000
`endif

// >>> rtl/aist_timing.v
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "aist_defines.vh"
module aist_timing #(
  parameter W = 16
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire ext_timebase_i,
  input wire ext_scan_strobe_i,
  input wire ext_conversion_strobe_i,
  input wire acq_begin_trig_i,
  input wire acq_ref_stop_trig_i,
  input wire acq_gate_trig_i,
  output reg scan_strobe_o,
  output reg conversion_strobe_n_o,
  output reg conv_start_o,
  output reg hold_done_pulse_o,
  output reg acq_begin_trig_o,
  output reg sample_wr_o,
  output reg [W-1:0] sample_addr_o,
  output reg acq_running_o
);

localparam integer TB20_I = `AIST_TB20_NS / `AIST_CLK_NS;
localparam integer TB100K_I = `AIST_TB100K_NS / `AIST_CLK_NS;
localparam [W-1:0] TB20_CNT = TB20_I[W-1:0];
localparam [W-1:0] TB100K_CNT = TB100K_I[W-1:0];
localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
localparam [3:0] ST_IDLE = 4'h1;
localparam [3:0] ST_ACQ = 4'h2;
localparam [3:0] ST_ARMED = 4'h4;
localparam [3:0] ST_POST = 4'h8;

function edge_of;
  input cur;
  input prev;
  input fall;
  begin
    edge_of = fall ? (prev & ~cur) : (cur & ~prev);
  end
endfunction

function [31:0] byte_merge;
  input [31:0] old;
  input [31:0] dat;
  input [3:0] sel;
  begin
    byte_merge[7:0] = sel[0] ? dat[7:0] : old[7:0];
    byte_merge[15:8] = sel[1] ? dat[15:8] : old[15:8];
    byte_merge[23:16] = sel[2] ? dat[23:16] : old[23:16];
    byte_merge[31:24] = sel[3] ? dat[31:24] : old[31:24];
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers
reg [5:0] sync1_reg;
reg [5:0] sync2_reg;
reg [5:0] prev_reg;
wire [5:0] pins = {acq_gate_trig_i, acq_ref_stop_trig_i, acq_begin_trig_i,
  ext_conversion_strobe_i, ext_scan_strobe_i, ext_timebase_i};

always @(posedge clk_i) begin
  if (rst_i) begin
    sync1_reg <= 6'h00;
    sync2_reg <= 6'h00;
    prev_reg <= 6'h00;
  end else begin
    sync1_reg <= pins;
    sync2_reg <= sync1_reg;
    prev_reg <= sync2_reg;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Registers
reg [`AIST_CTRL_W-1:0] ctrl_reg;
reg [W-1:0] scan_div_reg;
reg [W-1:0] scan_dly_reg;
reg [W-1:0] conv_div_reg;
reg [W-1:0] conv_dly_reg;
reg [W-1:0] chans_reg;
reg [W-1:0] buf_reg;
reg [W-1:0] pre_reg;
reg [3:0] state_reg;
reg [W-1:0] samples_reg;
reg [W-1:0] post_reg;
reg wrapped_reg;
reg sw_start_reg;
reg sw_stop_reg;
wire wb_req = wb_cyc_i & wb_stb_i;
wire wb_wr = wb_req & wb_we_i & wb_ack_o;
wire [3:0] idx = wb_adr_i[5:2];
wire [31:0] ctrl_wide = {{(32-`AIST_CTRL_W){1'b0}}, ctrl_reg};
reg [31:0] rd_mux;

always @* begin
  rd_mux = 32'h00000000;
  case (idx)
    `AIST_IDX_CTRL: rd_mux = ctrl_wide;
    `AIST_IDX_SCAN_DIV: rd_mux[W-1:0] = scan_div_reg;
    `AIST_IDX_SCAN_DLY: rd_mux[W-1:0] = scan_dly_reg;
    `AIST_IDX_CONV_DIV: rd_mux[W-1:0] = conv_div_reg;
    `AIST_IDX_CONV_DLY: rd_mux[W-1:0] = conv_dly_reg;
    `AIST_IDX_CHANS: rd_mux[W-1:0] = chans_reg;
    `AIST_IDX_BUF: rd_mux[W-1:0] = buf_reg;
    `AIST_IDX_PRE: rd_mux[W-1:0] = pre_reg;
    `AIST_IDX_STATUS: rd_mux[4:0] = {wrapped_reg, state_reg};
    `AIST_IDX_COUNT: rd_mux[W-1:0] = samples_reg;
    default: rd_mux = 32'h00000000;
  endcase
end

// Full word merge, so control bits above bit 15 stay writable
wire [31:0] wr_merged = byte_merge(rd_mux, wb_dat_i, wb_sel_i);

// Ack one cycle after the request; write lands on the acked edge
always @(posedge clk_i) begin
  if (rst_i) begin
    wb_ack_o <= 1'b0;
    wb_dat_o <= 32'h00000000;
    ctrl_reg <= `AIST_CTRL_RST;
    scan_div_reg <= `AIST_DIV_RST;
    scan_dly_reg <= `AIST_SCAN_DLY_RST;
    conv_div_reg <= `AIST_DIV_RST;
    conv_dly_reg <= `AIST_CONV_DLY_RST;
    chans_reg <= `AIST_CHANS_RST;
    buf_reg <= `AIST_BUF_RST;
    pre_reg <= {W{1'b0}};
    sw_start_reg <= 1'b0;
    sw_stop_reg <= 1'b0;
  end else begin
    wb_ack_o <= wb_req & ~wb_ack_o;
    if (wb_req & ~wb_ack_o)
      wb_dat_o <= rd_mux;
    sw_start_reg <= wb_wr & (idx == `AIST_IDX_CTRL) & wb_sel_i[0] &
      wb_dat_i[`AIST_C_START];
    sw_stop_reg <= wb_wr & (idx == `AIST_IDX_CTRL) & wb_sel_i[0] &
      wb_dat_i[`AIST_C_STOP];
    if (wb_wr) begin
      case (idx)
        `AIST_IDX_CTRL: ctrl_reg <= wr_merged[`AIST_CTRL_W-1:0] &
          ~`AIST_CTRL_PULSE_MASK;
        `AIST_IDX_SCAN_DIV: scan_div_reg <= wr_merged[W-1:0];
        `AIST_IDX_SCAN_DLY: scan_dly_reg <= wr_merged[W-1:0];
        `AIST_IDX_CONV_DIV: conv_div_reg <= wr_merged[W-1:0];
        `AIST_IDX_CONV_DLY: conv_dly_reg <= wr_merged[W-1:0];
        `AIST_IDX_CHANS: chans_reg <= wr_merged[W-1:0];
        `AIST_IDX_BUF: buf_reg <= wr_merged[W-1:0];
        `AIST_IDX_PRE: pre_reg <= wr_merged[W-1:0];
        default: ;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Timebases
reg [W-1:0] tb20_cnt_reg;
reg [W-1:0] tb100k_cnt_reg;
wire tb20_tick = (tb20_cnt_reg == ONE);
wire tb100k_tick = (tb100k_cnt_reg == ONE);
wire ext_tb_tick = edge_of(sync2_reg[0], prev_reg[0],
  ctrl_reg[`AIST_C_TB_FALL]);
wire [1:0] tb_sel = ctrl_reg[`AIST_C_TB_HI:`AIST_C_TB_LO];
wire scan_tb_tick = (tb_sel == `AIST_TB_20M) ? tb20_tick :
  (tb_sel == `AIST_TB_100K) ? tb100k_tick :
  (tb_sel == `AIST_TB_EXT) & ext_tb_tick;
wire conv_tb_tick = ctrl_reg[`AIST_C_CTB_20M] ? tb20_tick :
  scan_tb_tick;

always @(posedge clk_i) begin
  if (rst_i) begin
    tb20_cnt_reg <= TB20_CNT;
    tb100k_cnt_reg <= TB100K_CNT;
  end else begin
    tb20_cnt_reg <= tb20_tick ? TB20_CNT : tb20_cnt_reg - ONE;
    tb100k_cnt_reg <= tb100k_tick ? TB100K_CNT : tb100k_cnt_reg - ONE;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Trigger edges and gating
wire running = (state_reg != ST_IDLE);
wire gate_on = ~(sync2_reg[5] ^ ctrl_reg[`AIST_C_GATE_HIGH]);
wire begin_edge = edge_of(sync2_reg[3], prev_reg[3],
  ctrl_reg[`AIST_C_BEGIN_FALL]);
wire ref_edge = edge_of(sync2_reg[4], prev_reg[4],
  ctrl_reg[`AIST_C_REF_FALL]);
wire start_go = ~running & (sw_start_reg |
  (ctrl_reg[`AIST_C_HW_BEGIN] & begin_edge));
wire single = ctrl_reg[`AIST_C_SINGLE];
wire ext_scan_edge = edge_of(sync2_reg[1], prev_reg[1],
  ctrl_reg[`AIST_C_SCAN_FALL]);
wire ext_conv_edge = edge_of(sync2_reg[2], prev_reg[2],
  ctrl_reg[`AIST_C_CONV_FALL]);

////////////////////////////////////////////////////////////////////////////////
// Scan and conversion strobes
reg [W-1:0] scan_cnt_reg;
reg [W-1:0] conv_cnt_reg;
reg [W-1:0] conv_left_reg;
reg hold_dly_reg;
wire int_scan = scan_tb_tick & (scan_cnt_reg <= ONE);
wire int_conv = conv_tb_tick & (conv_cnt_reg <= ONE) &
  (conv_left_reg != {W{1'b0}});
wire scan_raw = single ? ext_conv_edge :
  (ctrl_reg[`AIST_C_SCAN_EXT] ? ext_scan_edge : int_scan);
wire conv_raw = single ? ext_conv_edge :
  (ctrl_reg[`AIST_C_CONV_EXT] ? ext_conv_edge : int_conv);
wire scan_acc = scan_raw & running & ~gate_on &
  (conv_left_reg == {W{1'b0}});
wire conv_acc = conv_raw & ((conv_left_reg != {W{1'b0}}) |
  (single & scan_acc));
wire scan_done = conv_acc & ((scan_acc & (chans_reg == ONE)) |
  (~scan_acc & (conv_left_reg == ONE)));
wire stop_now;

// Internal scan counter holds while gated or idle
always @(posedge clk_i) begin
  if (rst_i) begin
    scan_cnt_reg <= `AIST_SCAN_DLY_RST;
  end else if (start_go) begin
    scan_cnt_reg <= scan_dly_reg;
  end else if (running & ~gate_on & scan_tb_tick) begin
    scan_cnt_reg <= int_scan ? scan_div_reg : scan_cnt_reg - ONE;
  end
end

always @(posedge clk_i) begin
  if (rst_i) begin
    conv_cnt_reg <= `AIST_CONV_DLY_RST;
    conv_left_reg <= {W{1'b0}};
  end else begin
    if (stop_now | ~running) begin
      conv_left_reg <= {W{1'b0}};
    end else if (scan_acc) begin
      conv_left_reg <= chans_reg - {{(W-1){1'b0}}, conv_acc};
    end else if (conv_acc) begin
      conv_left_reg <= conv_left_reg - ONE;
    end
    // Reload with the delay from a scan to its first conversion, the period within one
    if (scan_acc | scan_done | ~running) begin
      conv_cnt_reg <= conv_dly_reg;
    end else if (conv_tb_tick & (conv_left_reg != {W{1'b0}})) begin
      conv_cnt_reg <= int_conv ? conv_div_reg : conv_cnt_reg - ONE;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Acquisition sequencing and sample buffer pointer
reg [3:0] state_next;
wire [W-1:0] post_target = buf_reg - pre_reg;
wire cont = ctrl_reg[`AIST_C_CONT];
wire ref_en = ctrl_reg[`AIST_C_REF_EN];
wire [W-1:0] samples_inc = samples_reg + ONE;
wire fin_done = scan_done & ~cont & ~ref_en & (samples_inc >= buf_reg);
wire post_done = (state_reg == ST_POST) & scan_done & (post_reg <= ONE);
assign stop_now = sw_stop_reg | fin_done | post_done;

always @* begin
  state_next = state_reg;
  case (state_reg)
    ST_IDLE: begin
      if (start_go)
        state_next = (ref_en & (pre_reg == {W{1'b0}})) ? ST_ARMED : ST_ACQ;
    end
    ST_ACQ: begin
      if (stop_now)
        state_next = ST_IDLE;
      else if (ref_en & scan_done & (samples_inc >= pre_reg))
        state_next = ST_ARMED;
    end
    ST_ARMED: begin
      if (sw_stop_reg)
        state_next = ST_IDLE;
      else if (ref_edge)
        state_next = (post_target == {W{1'b0}}) ? ST_IDLE : ST_POST;
    end
    ST_POST: begin
      if (stop_now)
        state_next = ST_IDLE;
    end
    default: state_next = ST_IDLE;
  endcase
end

always @(posedge clk_i) begin
  if (rst_i) begin
    state_reg <= ST_IDLE;
    samples_reg <= {W{1'b0}};
    post_reg <= {W{1'b0}};
    wrapped_reg <= 1'b0;
    sample_addr_o <= {W{1'b0}};
    sample_wr_o <= 1'b0;
  end else begin
    state_reg <= state_next;
    sample_wr_o <= scan_done & running;
    if (start_go) begin
      samples_reg <= {W{1'b0}};
      wrapped_reg <= 1'b0;
      sample_addr_o <= {W{1'b0}};
    end else if (scan_done & running) begin
      samples_reg <= samples_inc;
      // Ring pointer: a full buffer overwrites its oldest entry
      if (sample_addr_o + ONE >= buf_reg) begin
        sample_addr_o <= {W{1'b0}};
        wrapped_reg <= 1'b1;
      end else begin
        sample_addr_o <= sample_addr_o + ONE;
      end
    end
    if ((state_reg == ST_ARMED) & ref_edge)
      post_reg <= post_target;
    else if ((state_reg == ST_POST) & scan_done)
      post_reg <= post_reg - ONE;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Output strobes
always @(posedge clk_i) begin
  if (rst_i) begin
    scan_strobe_o <= 1'b0;
    conversion_strobe_n_o <= 1'b1;
    conv_start_o <= 1'b0;
    hold_dly_reg <= 1'b0;
    hold_done_pulse_o <= 1'b0;
    acq_begin_trig_o <= 1'b0;
    acq_running_o <= 1'b0;
  end else begin
    // Level form stays high until the scan's last conversion
    scan_strobe_o <= ctrl_reg[`AIST_C_LEVEL_OUT] ?
      ((scan_acc | (conv_left_reg != {W{1'b0}})) & ~scan_done) :
      scan_acc;
    conversion_strobe_n_o <= ~conv_acc;
    conv_start_o <= conv_acc;
    hold_dly_reg <= conv_acc;
    hold_done_pulse_o <= hold_dly_reg ^ ctrl_reg[`AIST_C_HOLD_LOW];
    acq_begin_trig_o <= start_go;
    acq_running_o <= (state_next != ST_IDLE);
  end
end

endmodule // aist_timing

// >>> dv/aist_timing_props.sv
`timescale 1ns/1ps
module aist_timing_props (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire scan_strobe_o,
  input wire conversion_strobe_n_o,
  input wire conv_start_o,
  input wire hold_done_pulse_o,
  input wire acq_begin_trig_o,
  input wire sample_wr_o,
  input wire acq_running_o
);
  reg pend_reg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Scan taken, its conversions not all in yet
  always @(posedge clk_i) begin
    if (rst_i || acq_begin_trig_o || sample_wr_o) begin
      pend_reg <= 1'b0;
    end else if ($rose(scan_strobe_o)) begin
      pend_reg <= 1'b1;
    end
  end
  //////////////////////////////////////////////
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_hold;
    $changed(hold_done_pulse_o) ##1 $changed(hold_done_pulse_o);
  endsequence
  property p_wb_ack;
    s_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bad ack timing");
  property p_conv_low;
    conversion_strobe_n_o == !conv_start_o;
  endproperty
  a_conv_low: assert property (p_conv_low) else $error("strobe level");
  property p_hold;
    conv_start_o |=> s_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("no hold pulse");
  property p_begin;
    acq_begin_trig_o |-> $rose(acq_running_o) ##1 !acq_begin_trig_o;
  endproperty
  a_begin: assert property (p_begin) else $error("begin pulse");
  property p_run_begin;
    $rose(acq_running_o) |-> acq_begin_trig_o;
  endproperty
  a_run_begin: assert property (p_run_begin) else $error("start");
  property p_scan_run;
    $rose(scan_strobe_o) |-> $past(acq_running_o);
  endproperty
  a_scan_run: assert property (p_scan_run) else $error("idle scan");
  property p_scan_once;
    $rose(scan_strobe_o) |-> !pend_reg;
  endproperty
  a_scan_once: assert property (p_scan_once) else $error("rescan");
  property p_conv_scan;
    conv_start_o |-> pend_reg || scan_strobe_o;
  endproperty
  a_conv_scan: assert property (p_conv_scan) else $error("stray conv");
  property p_wr_conv;
    sample_wr_o |-> conv_start_o;
  endproperty
  a_wr_conv: assert property (p_wr_conv) else $error("sample early");
endmodule // aist_timing_props

bind aist_timing aist_timing_props i_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .scan_strobe_o(scan_strobe_o),
  .conversion_strobe_n_o(conversion_strobe_n_o),
  .conv_start_o(conv_start_o), .hold_done_pulse_o(hold_done_pulse_o),
  .acq_begin_trig_o(acq_begin_trig_o), .sample_wr_o(sample_wr_o),
  .acq_running_o(acq_running_o));

// >>> dv/aist_src_model.sv
`timescale 1ns/1ps
module aist_src_model (
  input wire clk_i,
  input wire clr_i,
  input wire conv_start_i,
  output logic ext_timebase_o,
  output logic [3:0] pins_o,
  output logic gate_o,
  output int conv_count_o
);
  initial begin
    ext_timebase_o = 1'b0;
    pins_o = 4'h0;
    gate_o = 1'b0;
    conv_count_o = 0;
  end
  int tb_div = 0;
  // Free-running timebase, one edge every four clocks
  always @(posedge clk_i) begin
    if (tb_div == 3) begin
      tb_div <= 0;
      ext_timebase_o <= ~ext_timebase_o;
    end else begin
      tb_div <= tb_div + 1;
    end
  end
  always @(posedge clk_i) begin
    if (clr_i) begin
      conv_count_o <= 0;
    end else if (conv_start_i) begin
      conv_count_o <= conv_count_o + 1;
    end
  end
  // Wide enough for the two-flop synchroniser
  task pulse(input int n);
    pins_o[n] <= 1'b1;
    repeat (4) @(posedge clk_i);
    pins_o[n] <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
  task set_gate(input logic v);
    gate_o <= v;
  endtask
endmodule // aist_src_model

// >>> dv/ai_sample_convert_timing_bench.sv
`timescale 1ns/1ps
`include "aist_defines.vh"
module ai_sample_convert_timing_bench;
  typedef struct {logic [18:0] ctrl; int chans, dly, nbuf, per;} aist_row_t;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic clr = 0;
  logic [5:0] wb_adr_i = 6'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [3:0] pins;
  logic [3:0] wb_sel_i = 4'hf;
  logic [15:0] addr;
  logic wb_ack_o, tb, gate, scan_strobe_o, conversion_strobe_n_o, conv_start_o;
  logic hold_done_pulse_o, acq_begin_trig_o, sample_wr_o, acq_running_o;
  int n_fail = 0, checks_done = 0, n_conv, n_scan = 0, n_wr = 0, n_hi = 0;
  int t_now = 0, t_beg = 0, t_scan = 0, i;
  int exp_rst [11] = '{32'h8000, 4, 2, 4, 3, 1, 16, 0, 1, 0, 0};
  aist_row_t rows [4] = '{'{19'h08000, 3, 2, 4, 10},
    '{19'h18000, 2, 1, 2, 10}, '{19'h08080, 1, 1, 1, 2000},
    '{19'h2c100, 2, 3, 3, 8}};
  initial forever #2.5 clk_i = ~clk_i;
  aist_timing i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ext_timebase_i(tb), .ext_scan_strobe_i(pins[0]),
    .ext_conversion_strobe_i(pins[1]), .acq_begin_trig_i(pins[2]),
    .acq_ref_stop_trig_i(pins[3]), .acq_gate_trig_i(gate),
    .scan_strobe_o(scan_strobe_o), .conversion_strobe_n_o(conversion_strobe_n_o),
    .conv_start_o(conv_start_o), .hold_done_pulse_o(hold_done_pulse_o),
    .acq_begin_trig_o(acq_begin_trig_o), .sample_wr_o(sample_wr_o),
    .sample_addr_o(addr), .acq_running_o(acq_running_o));
  aist_src_model i_src (.clk_i(clk_i), .clr_i(clr), .conv_start_i(conv_start_o),
    .ext_timebase_o(tb), .pins_o(pins), .gate_o(gate), .conv_count_o(n_conv));
  always @(posedge clk_i) begin
    t_now <= t_now + 1;
    if (acq_begin_trig_o) t_beg <= t_now;
    if ($rose(scan_strobe_o) && t_scan <= t_beg) t_scan <= t_now;
    n_scan <= clr ? 0 : n_scan + $rose(scan_strobe_o);
    n_wr <= clr ? 0 : n_wr + sample_wr_o;
    n_hi <= clr ? 0 : n_hi + scan_strobe_o;
  end
  //////////////////////////////////////////////
  task complete_run;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task wb(input logic we, input logic [3:0] idx, input logic [31:0] d);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
    if (k == 20) begin
      n_fail++;
      complete_run();
    end
  endtask
  task start(input logic [18:0] c);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    wb(1'b1, `AIST_IDX_CTRL, {13'h0, c | 19'h1});
    repeat (2) @(posedge clk_i);
  endtask
  task wait_idle(input int lim);
    int k;
    for (k = 0; k < lim && acq_running_o !== 1'b0; k++) @(posedge clk_i);
    // Last sample lands as the run flag drops and the hold pulse after it
    repeat (3) @(posedge clk_i);
    if (k >= lim) begin
      n_fail++;
      complete_run();
    end
  endtask
  //////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(conversion_strobe_n_o, 1);
    wb(1'b1, `AIST_IDX_STATUS, 32'h0);
    for (i = 0; i < 11; i++) begin
      wb(1'b0, i[3:0], 32'h0);
      chk(rd, exp_rst[i]);
    end
    wb_sel_i <= 4'h2;
    wb(1'b1, `AIST_IDX_SCAN_DIV, 32'h00001299);
    wb_sel_i <= 4'hf;
    wb(1'b0, `AIST_IDX_SCAN_DIV, 32'h0);
    chk(rd, 32'h00001204);
    wb(1'b1, `AIST_IDX_SCAN_DIV, `AIST_DIV_RST);
    $display("reset test done");
    foreach (rows[k]) begin
      wb(1'b1, `AIST_IDX_CHANS, rows[k].chans);
      wb(1'b1, `AIST_IDX_SCAN_DLY, rows[k].dly);
      wb(1'b1, `AIST_IDX_BUF, rows[k].nbuf);
      start(rows[k].ctrl);
      wait_idle(20000);
      chk(n_wr, rows[k].nbuf);
      chk(n_scan, rows[k].nbuf);
      chk(n_conv, rows[k].nbuf * rows[k].chans);
      chk(t_scan - t_beg >= (rows[k].dly - 1) * rows[k].per &&
        t_scan - t_beg <= rows[k].dly * rows[k].per + 12, 1);
      chk(n_hi > n_scan, rows[k].ctrl[16]);
      chk(hold_done_pulse_o, rows[k].ctrl[17]);
      chk(addr, 16'h0000);
      wb(1'b0, `AIST_IDX_COUNT, 32'h0);
      chk(rd, rows[k].nbuf);
    end
    $display("row tests done");
    // Strobes while idle go nowhere
    wb(1'b1, `AIST_IDX_CTRL, 32'h8010);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    i_src.pulse(0);
    chk(n_scan, 0);
    wb(1'b1, `AIST_IDX_CHANS, 32'h2);
    wb(1'b1, `AIST_IDX_BUF, 32'h2);
    start(19'h08030);
    i_src.set_gate(1'b1);
    repeat (4) @(posedge clk_i);
    i_src.pulse(0);
    i_src.set_gate(1'b0);
    repeat (4) @(posedge clk_i);
    i_src.pulse(1);
    i_src.pulse(0);
    i_src.pulse(0);
    i_src.pulse(1);
    i_src.pulse(1);
    i_src.pulse(1);
    i_src.pulse(0);
    i_src.pulse(1);
    i_src.pulse(1);
    wait_idle(100);
    chk(n_scan, 2);
    chk(n_conv, 4);
    chk(n_wr, 2);
    $display("external strobe test done");
    wb(1'b1, `AIST_IDX_CHANS, 32'h1);
    wb(1'b1, `AIST_IDX_BUF, 32'h3);
    start(19'h08060);
    repeat (3) i_src.pulse(1);
    wait_idle(100);
    chk(n_conv, 3);
    chk(n_wr, 3);
    wb(1'b1, `AIST_IDX_CTRL, 32'h4a004);
    i_src.pulse(2);
    chk(acq_running_o, 1);
    repeat (300) @(posedge clk_i);
    chk(acq_running_o, 1);
    wb(1'b1, `AIST_IDX_CTRL, 32'h4a006);
    wait_idle(50);
    $display("single and trigger tests done");
    wb(1'b1, `AIST_IDX_BUF, 32'h4);
    wb(1'b1, `AIST_IDX_PRE, 32'h2);
    start(19'h08008);
    i_src.pulse(3);
    repeat (600) @(posedge clk_i);
    chk(acq_running_o, 1);
    wb(1'b0, `AIST_IDX_STATUS, 32'h0);
    chk(rd[4:0], 5'h14);
    // Trigger just after a sample, so none lands before the edge counts
    for (i = 0; i < 100 && sample_wr_o !== 1'b1; i++) @(posedge clk_i);
    if (i >= 100) begin
      n_fail++;
      complete_run();
    end
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    i_src.pulse(3);
    wait_idle(400);
    chk(n_wr, 2);
    $display("reference test done");
    complete_run();
  end
endmodule // ai_sample_convert_timing_bench
